/* sbda_pkg.sv */
package sbda_pkg;
  // Address map.
  localparam logic [2:0] SEG_BOOT = 3'h0;
  localparam logic [2:0] SEG_EXT = 3'h2;
  localparam logic [2:0] SEG_ISRAM = 3'h3;
  localparam logic [2:0] SEG_LSRAM = 3'h4;
  localparam logic [31:0] PERIPH_BASE = 32'hfffc0000;
  localparam logic [31:0] PERIPH_LAST = 32'hfffeffff;
  localparam int SRAM_AW = 12;
  localparam int SLOT_LSB = 12;
  localparam int NUM_PSEL = 21;
  localparam int NUM_CS = 4;
  localparam int SECTION_LSB = 26;

  // Boot map select encodings.
  localparam logic [1:0] MAP_EXT = 2'h0;
  localparam logic [1:0] MAP_ISRAM = 2'h1;
  localparam logic [1:0] MAP_LSRAM = 2'h2;
  localparam logic [1:0] MAP_RESET = 2'h0;

  // Assigned peripheral slot numbers, indexed by select line.
  localparam logic [5:0] SLOT_TAB [NUM_PSEL] = '{
    6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h1b, 6'h1c, 6'h1d, 6'h1e,
    6'h1f, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h26, 6'h26};

  // Masters, lowest priority first.
  typedef enum logic [1:0] {
    MST_CPU = 2'h0,
    MST_XFER = 2'h1,
    MST_DISP = 2'h3
  } sbda_master_t;

  // Slave targets.
  typedef enum logic [2:0] {
    TGT_NONE = 3'h0,
    TGT_EXT = 3'h1,
    TGT_ISRAM = 3'h2,
    TGT_LSRAM = 3'h3,
    TGT_APB = 3'h4,
    TGT_SINK = 3'h5
  } sbda_target_t;

  // APB bridge phases.
  typedef enum logic [1:0] {
    APB_IDLE = 2'h0,
    APB_SETUP = 2'h1,
    APB_ACCESS = 2'h3
  } sbda_apb_state_t;

  // One master's request.
  typedef struct packed {
    logic req;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] haddr;
    logic [31:0] hwdata;
  } sbda_mreq_t;

  // Response back to masters.
  typedef struct packed {
    logic hready;
    logic [1:0] hresp;
    logic [31:0] hrdata;
  } sbda_resp_t;
endpackage

/* sbda_sram.sv */
`timescale 1ns/1ps
`default_nettype none
// Single-port word memory, registered read data.
module sbda_sram (
  // Clock.
  input wire logic clk_sys,
  // Access port.
  input wire logic en,
  input wire logic we,
  input wire logic [sbda_pkg::SRAM_AW-1:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);
  logic [31:0] mem [2**sbda_pkg::SRAM_AW];

  // Memory has no reset; contents are undefined at power-up.
  always_ff @(posedge clk_sys) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
    if (en && !we) begin
      rdata <= mem[addr];
    end
  end
endmodule
`default_nettype wire

/* sbda_fabric.sv */
`timescale 1ns/1ps
`default_nettype none
module sbda_fabric (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Boot map select from the reset and clock unit.
  input wire logic [1:0] map_select_field,
  // Master requests.
  input wire sbda_pkg::sbda_mreq_t disp_req,
  input wire sbda_pkg::sbda_mreq_t xfer_req,
  input wire sbda_pkg::sbda_mreq_t cpu_req,
  // Grants and shared response.
  output logic [2:0] grant_reg,
  output sbda_pkg::sbda_resp_t resp_reg,
  // Processor local SRAM port.
  input wire logic lsram_en,
  input wire logic lsram_we,
  input wire logic [31:0] lsram_addr,
  input wire logic [31:0] lsram_wdata,
  output logic [31:0] lsram_rdata,
  // External memory controller port.
  output logic [3:0] ext_cs_reg,
  output logic ext_write_reg,
  output logic [31:0] ext_addr_reg,
  output logic [31:0] ext_wdata_reg,
  input wire logic [31:0] ext_rdata,
  input wire logic ext_ready,
  // APB side.
  output logic [20:0] psel_reg,
  output logic penable_reg,
  output logic pwrite_reg,
  output logic [31:0] paddr_reg,
  output logic [31:0] pwdata_reg,
  input wire logic [31:0] prdata
);
  // Decode one address into a target.
  function automatic sbda_pkg::sbda_target_t decode(input logic [31:0] a, input logic [1:0] ms);
    logic [2:0] seg;
    seg = a[31:29];
    decode = sbda_pkg::TGT_NONE;
    if (seg == sbda_pkg::SEG_BOOT) begin
      case (ms)
        sbda_pkg::MAP_EXT: decode = sbda_pkg::TGT_EXT;
        sbda_pkg::MAP_ISRAM: decode = sbda_pkg::TGT_ISRAM;
        sbda_pkg::MAP_LSRAM: decode = sbda_pkg::TGT_LSRAM;
        default: decode = sbda_pkg::TGT_NONE;
      endcase
    end else if (seg == sbda_pkg::SEG_EXT) begin
      decode = sbda_pkg::TGT_EXT;
    end else if (seg == sbda_pkg::SEG_ISRAM) begin
      decode = sbda_pkg::TGT_ISRAM;
    end else if (seg == sbda_pkg::SEG_LSRAM) begin
      decode = sbda_pkg::TGT_LSRAM;
    end else if (a >= sbda_pkg::PERIPH_BASE && a <= sbda_pkg::PERIPH_LAST) begin
      decode = sbda_pkg::TGT_APB;
    end
    // Upper external sections sink quietly.
    if (decode == sbda_pkg::TGT_EXT && a[sbda_pkg::SECTION_LSB+2:sbda_pkg::SECTION_LSB] >= 3'(sbda_pkg::NUM_CS)) begin
      decode = sbda_pkg::TGT_SINK;
    end
  endfunction

  // Arbitration and transfer state.
  logic [2:0] grant_next;
  sbda_pkg::sbda_mreq_t cur;
  logic busy_reg, busy_next;
  logic lock_reg, lock_next;
  sbda_pkg::sbda_target_t tgt_reg, tgt_next;
  logic wr_reg, wr_next;
  logic [31:0] addr_reg, addr_next;
  logic [31:0] wd_reg, wd_next;
  sbda_pkg::sbda_apb_state_t apb_reg, apb_next;
  sbda_pkg::sbda_resp_t resp_next;
  logic [3:0] ext_cs_next;
  logic [20:0] psel_next;
  logic penable_next;
  logic isram_en, isram_phase_reg, isram_phase_next;
  logic lsram_fab_en;
  logic [31:0] isram_rdata;
  logic [20:0] slot_hit;
  sbda_pkg::sbda_target_t dec;

  // Current master's bus, selected by the held grant.
  always_comb begin
    cur = cpu_req;
    if (grant_reg[2]) begin
      cur = disp_req;
    end else if (grant_reg[1]) begin
      cur = xfer_req;
    end
    dec = decode(cur.haddr, map_select_field);
  end

  // Local SRAM serves the processor's zero-wait port, or a fabric transfer that the processor owns.
  // The fabric access takes the port for one cycle; the processor never drives both paths at once.
  assign lsram_fab_en = busy_reg && tgt_reg == sbda_pkg::TGT_LSRAM && grant_reg[0] && !isram_phase_reg;
  sbda_sram u_lsram (
    .clk_sys(clk_sys),
    .en(lsram_en || lsram_fab_en),
    .we(lsram_fab_en ? wr_reg : lsram_we),
    .addr(lsram_fab_en ? addr_reg[sbda_pkg::SRAM_AW+1:2] : lsram_addr[sbda_pkg::SRAM_AW+1:2]),
    .wdata(lsram_fab_en ? wd_reg : lsram_wdata),
    .rdata(lsram_rdata)
  );

  // Shared internal SRAM behind the fabric.
  sbda_sram u_isram (
    .clk_sys(clk_sys),
    .en(isram_en),
    .we(wr_reg),
    .addr(addr_reg[sbda_pkg::SRAM_AW+1:2]),
    .wdata(wd_reg),
    .rdata(isram_rdata)
  );
  assign isram_en = busy_reg && tgt_reg == sbda_pkg::TGT_ISRAM && !isram_phase_reg;

  // Peripheral slot match for each select line.
  genvar gi;
  generate
    for (gi = 0; gi < sbda_pkg::NUM_PSEL; gi++) begin : g_slot
      assign slot_hit[gi] = addr_reg[17:sbda_pkg::SLOT_LSB] == sbda_pkg::SLOT_TAB[gi];
    end
  endgenerate

  // Next-state logic for arbitration, decode and slave sequencing.
  always_comb begin
    grant_next = grant_reg;
    busy_next = busy_reg;
    lock_next = lock_reg;
    tgt_next = tgt_reg;
    wr_next = wr_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    apb_next = apb_reg;
    isram_phase_next = isram_phase_reg;
    resp_next = resp_reg;
    resp_next.hready = 1'b0;
    ext_cs_next = ext_cs_reg;
    psel_next = psel_reg;
    penable_next = 1'b0;
    if (!busy_reg) begin
      if (cur.req && cur.htrans[1]) begin
        busy_next = 1'b1;
        tgt_next = dec;
        wr_next = cur.hwrite;
        addr_next = cur.haddr;
        wd_next = cur.hwdata;
        lock_next = cur.htrans == 2'h3 || cur.req;
        if (dec == sbda_pkg::TGT_EXT) begin
          ext_cs_next = 4'h1 << cur.haddr[27:26];
        end
      end else if (!lock_reg || !cur.req) begin
        // Boundary: reselect by fixed priority, park on processor.
        lock_next = 1'b0;
        if (disp_req.req) begin
          grant_next = 3'h4;
        end else if (xfer_req.req) begin
          grant_next = 3'h2;
        end else begin
          grant_next = 3'h1;
        end
      end
    end else begin
      case (tgt_reg)
        sbda_pkg::TGT_ISRAM, sbda_pkg::TGT_LSRAM: begin
          isram_phase_next = 1'b1;
          if (tgt_reg == sbda_pkg::TGT_LSRAM && !grant_reg[0]) begin
            // Other masters never reach the processor's private memory.
            isram_phase_next = 1'b0;
            busy_next = 1'b0;
            resp_next = '{hready: 1'b1, hresp: 2'h1, hrdata: 32'h0};
          end else if (isram_phase_reg) begin
            isram_phase_next = 1'b0;
            busy_next = 1'b0;
            resp_next = '{hready: 1'b1, hresp: 2'h0, hrdata: isram_rdata};
            if (tgt_reg == sbda_pkg::TGT_LSRAM) begin
              resp_next.hrdata = lsram_rdata;
            end
          end
        end
        sbda_pkg::TGT_EXT: begin
          if (ext_ready) begin
            ext_cs_next = 4'h0;
            busy_next = 1'b0;
            resp_next = '{hready: 1'b1, hresp: 2'h0, hrdata: ext_rdata};
          end
        end
        sbda_pkg::TGT_APB: begin
          case (apb_reg)
            sbda_pkg::APB_IDLE: begin
              apb_next = sbda_pkg::APB_SETUP;
              psel_next = slot_hit;
            end
            sbda_pkg::APB_SETUP: begin
              apb_next = sbda_pkg::APB_ACCESS;
              penable_next = 1'b1;
            end
            sbda_pkg::APB_ACCESS: begin
              // Unassigned slots still finish, reading zero.
              apb_next = sbda_pkg::APB_IDLE;
              psel_next = 21'h0;
              busy_next = 1'b0;
              resp_next = '{hready: 1'b1, hresp: 2'h0, hrdata: (|psel_reg) ? prdata : 32'h0};
            end
            default: apb_next = sbda_pkg::APB_IDLE;
          endcase
        end
        sbda_pkg::TGT_SINK: begin
          busy_next = 1'b0;
          resp_next = '{hready: 1'b1, hresp: 2'h0, hrdata: 32'h0};
        end
        default: begin
          busy_next = 1'b0;
          resp_next = '{hready: 1'b1, hresp: 2'h1, hrdata: 32'h0};
        end
      endcase
    end
  end

  // Registers; grant resets to the processor as default master.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      grant_reg <= 3'h1;
      busy_reg <= 1'b0;
      lock_reg <= 1'b0;
      tgt_reg <= sbda_pkg::TGT_NONE;
      wr_reg <= 1'b0;
      addr_reg <= 32'h0;
      wd_reg <= 32'h0;
      apb_reg <= sbda_pkg::APB_IDLE;
      isram_phase_reg <= 1'b0;
      resp_reg <= '0;
      ext_cs_reg <= 4'h0;
      psel_reg <= 21'h0;
      penable_reg <= 1'b0;
    end else begin
      grant_reg <= grant_next;
      busy_reg <= busy_next;
      lock_reg <= lock_next;
      tgt_reg <= tgt_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      apb_reg <= apb_next;
      isram_phase_reg <= isram_phase_next;
      resp_reg <= resp_next;
      ext_cs_reg <= ext_cs_next;
      psel_reg <= psel_next;
      penable_reg <= penable_next;
    end
  end

  // Outbound address and data mirror the captured transfer.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ext_write_reg <= 1'b0;
      ext_addr_reg <= 32'h0;
      ext_wdata_reg <= 32'h0;
      pwrite_reg <= 1'b0;
      paddr_reg <= 32'h0;
      pwdata_reg <= 32'h0;
    end else begin
      ext_write_reg <= wr_next;
      ext_addr_reg <= addr_next;
      ext_wdata_reg <= wd_next;
      pwrite_reg <= wr_next;
      paddr_reg <= addr_next;
      pwdata_reg <= wd_next;
    end
  end
endmodule
`default_nettype wire

/* sbda_ext_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Memory controller stand-in that answers after a set wait, and peripheral stand-in that answers at once.
module sbda_ext_model #(
  parameter int WAIT = 3,
  parameter logic [31:0] EXT_DATA = 32'h5a5a_0001,
  parameter logic [31:0] APB_DATA = 32'h0000_a9b1
) (
  // Clock and selects.
  input wire logic clk_sys,
  input wire logic [3:0] ext_cs_reg,
  input wire logic [20:0] psel_reg,
  // Answers.
  output logic [31:0] ext_rdata,
  output logic ext_ready,
  output logic [31:0] prdata
);
  int cnt = 0;
  initial ext_ready = 1'b0;
  // Ready pulses once per select, so a stuck select is not answered twice.
  always @(posedge clk_sys) begin
    cnt <= (ext_cs_reg == 4'h0) ? 0 : cnt + 1;
    ext_ready <= (ext_cs_reg != 4'h0) && (cnt == WAIT - 1);
  end
  // Idle data is inverted so a stale capture never passes.
  assign ext_rdata = ext_ready ? EXT_DATA : ~EXT_DATA;
  assign prdata = (psel_reg != 21'h0) ? APB_DATA : ~APB_DATA;
endmodule
`default_nettype wire

/* sbda_fabric_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches arbitration, decode and handshake order at the fabric ports.
module sbda_fabric_checker (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Masters and grant.
  input wire sbda_pkg::sbda_mreq_t disp_req,
  input wire sbda_pkg::sbda_mreq_t xfer_req,
  input wire sbda_pkg::sbda_mreq_t cpu_req,
  input wire logic [2:0] grant_reg,
  input wire sbda_pkg::sbda_resp_t resp_reg,
  // Local port.
  input wire logic lsram_en,
  input wire logic lsram_we,
  input wire logic [31:0] lsram_addr,
  input wire logic [31:0] lsram_wdata,
  input wire logic [31:0] lsram_rdata,
  // Slave selects.
  input wire logic [3:0] ext_cs_reg,
  input wire logic [20:0] psel_reg,
  input wire logic penable_reg
);
  logic [31:0] g_addr;
  logic [11:0] la;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Address of the granted master, held by it for the whole transfer.
  always_comb g_addr = grant_reg[2] ? disp_req.haddr : (grant_reg[1] ? xfer_req.haddr : cpu_req.haddr);
  assign la = lsram_addr[13:2];
  property p_onehot; $onehot(grant_reg); endproperty
  a_onehot: assert property (p_onehot) else $error("grant not one-hot");
  property p_prio; $changed(grant_reg) && !grant_reg[2] |-> !$past(disp_req.req) && (grant_reg[1] || !$past(xfer_req.req)); endproperty
  a_prio: assert property (p_prio) else $error("grant skipped a higher master");
  property p_park; (!disp_req.req && !xfer_req.req && !cpu_req.req) [*4] |-> grant_reg == 3'h1; endproperty
  a_park: assert property (p_park) else $error("idle grant not parked");
  property p_hold; (grant_reg[2] && disp_req.req) || (grant_reg[1] && xfer_req.req) || (grant_reg[0] && cpu_req.req) |=> $stable(grant_reg); endproperty
  a_hold: assert property (p_hold) else $error("grant moved mid-transfer");
  property p_cs; ext_cs_reg != 4'h0 |-> !g_addr[28] && ext_cs_reg == (4'h1 << g_addr[27:26]); endproperty
  a_cs: assert property (p_cs) else $error("wrong section select");
  property p_psel; psel_reg != 21'h0 |-> g_addr >= sbda_pkg::PERIPH_BASE && g_addr <= sbda_pkg::PERIPH_LAST; endproperty
  a_psel: assert property (p_psel) else $error("peripheral select outside range");
  property p_setup; psel_reg != 21'h0 && !penable_reg |=> penable_reg && $stable(psel_reg); endproperty
  a_setup: assert property (p_setup) else $error("no access phase after setup");
  property p_access; penable_reg && psel_reg != 21'h0 |=> !penable_reg && resp_reg.hready; endproperty
  a_access: assert property (p_access) else $error("access phase not answered");
  property p_lsram; lsram_en && lsram_we ##1 lsram_en && !lsram_we && la == $past(la) |=> lsram_rdata == $past(lsram_wdata, 2); endproperty
  a_lsram: assert property (p_lsram) else $error("local read wrong or late");
  property p_pulse; resp_reg.hready |=> !resp_reg.hready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  c_disp: cover property (grant_reg == 3'h4);
  c_err: cover property (resp_reg.hready && resp_reg.hresp == 2'h1);
  c_apb: cover property (penable_reg && psel_reg != 21'h0);
endmodule
`default_nettype wire

/* system_bus_decode_arbiter_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module system_bus_decode_arbiter_tb;
  localparam logic [31:0] XD = 32'h5a5a_0001;
  localparam logic [31:0] AD = 32'h0000_a9b1;
  localparam logic [31:0] WD = 32'h1234_abcd;
  typedef struct {logic [1:0] m; logic [31:0] a; logic w; logic [1:0] r; logic [31:0] q; logic [3:0] cs;
    logic [20:0] ps;} sbda_row_t;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] map_sel = 2'h0;
  sbda_pkg::sbda_mreq_t mr [3] = '{default: '0};
  logic lsram_en = 1'b0, lsram_we = 1'b0;
  logic [31:0] lsram_addr = 32'h0, lsram_wdata = 32'h0;
  logic [2:0] grant_reg;
  sbda_pkg::sbda_resp_t resp_reg;
  logic [31:0] lsram_rdata, ext_rdata, prdata, q;
  logic [3:0] ext_cs_reg, cs_acc = 4'h0;
  logic [20:0] psel_reg, ps_acc = 21'h0;
  logic ext_ready, penable_reg;
  logic ext_write_q, pwrite_q;
  logic [31:0] ext_addr_q, ext_wdata_q, paddr_q, pwdata_q;
  logic [1:0] r;
  int bad_count = 0, tests_run = 0;
  int order [$];
  // Rows: map, address, write, response, read data, chip selects, peripheral selects.
  sbda_row_t rows [13] = '{
    '{2'h0, 32'h6000_0010, 1'b1, 2'h0, 32'h0, 4'h0, 21'h0}, '{2'h0, 32'h6000_4010, 1'b0, 2'h0, WD, 4'h0, 21'h0},
    '{2'h1, 32'h0000_0010, 1'b0, 2'h0, WD, 4'h0, 21'h0}, '{2'h0, 32'h4000_0000, 1'b0, 2'h0, XD, 4'h1, 21'h0},
    '{2'h0, 32'h4c00_0004, 1'b0, 2'h0, XD, 4'h8, 21'h0}, '{2'h0, 32'h5000_0000, 1'b0, 2'h0, 32'h0, 4'h0, 21'h0},
    '{2'h0, 32'h2000_0000, 1'b0, 2'h1, 32'h0, 4'h0, 21'h0}, '{2'h0, 32'ha000_0000, 1'b0, 2'h1, 32'h0, 4'h0, 21'h0},
    '{2'h0, 32'hfffb_f000, 1'b0, 2'h1, 32'h0, 4'h0, 21'h0}, '{2'h0, 32'hfffc_0000, 1'b0, 2'h0, AD, 4'h0, 21'h1},
    '{2'h0, 32'hfffe_5004, 1'b0, 2'h0, AD, 4'h0, 21'h2_0000}, '{2'h0, 32'hfffc_7000, 1'b0, 2'h0, 32'h0, 4'h0, 21'h0},
    '{2'h3, 32'h0000_0000, 1'b0, 2'h1, 32'h0, 4'h0, 21'h0}};
  sbda_fabric i_sbda_fabric (.clk_sys, .rstn, .map_select_field(map_sel), .disp_req(mr[2]), .xfer_req(mr[1]),
    .cpu_req(mr[0]), .grant_reg, .resp_reg, .lsram_en, .lsram_we, .lsram_addr, .lsram_wdata, .lsram_rdata,
    .ext_cs_reg, .ext_write_reg(ext_write_q), .ext_addr_reg(ext_addr_q), .ext_wdata_reg(ext_wdata_q), .ext_rdata,
    .ext_ready, .psel_reg, .penable_reg, .pwrite_reg(pwrite_q), .paddr_reg(paddr_q), .pwdata_reg(pwdata_q), .prdata);
  sbda_ext_model #(.WAIT(3), .EXT_DATA(XD), .APB_DATA(AD)) i_model (.clk_sys, .ext_cs_reg, .psel_reg,
    .ext_rdata, .ext_ready, .prdata);
  // Clock at 100 MHz.
  always #5 clk_sys = ~clk_sys;
  // Selects seen since the last clear, so one row's decode can be judged whole.
  always @(posedge clk_sys) begin
    cs_acc <= cs_acc | ext_cs_reg;
    ps_acc <= ps_acc | psel_reg;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One transfer; the request stands until the answer, then goes idle before release.
  task automatic run(input int m, input logic [31:0] a, input logic w, output logic [1:0] rr,
    output logic [31:0] qq);
    int i;
    @(negedge clk_sys);
    mr[m] = '{1'b1, 2'h2, w, a, WD};
    for (i = 0; i < 40 && !(resp_reg.hready === 1'b1 && grant_reg[m] === 1'b1); i++) @(negedge clk_sys);
    if (i == 40) begin
      bad_count++;
      conclude();
    end else begin
      rr = resp_reg.hresp;
      qq = resp_reg.hrdata;
      mr[m].htrans = 2'h0;
      @(negedge clk_sys);
      mr[m].req = 1'b0;
    end
  endtask
  // Reset is held for some cycles, outputs checked, masters cleared before release.
  task automatic rst(input int n);
    rstn = 1'b0;
    repeat (n) @(negedge clk_sys);
    check({grant_reg, ext_cs_reg, psel_reg, resp_reg.hready}, {3'h1, 26'h0});
    mr = '{default: '0};
    rstn = 1'b1;
  endtask
  initial begin
    rst(12);
    foreach (rows[k]) begin
      map_sel = rows[k].m;
      cs_acc = 4'h0;
      ps_acc = 21'h0;
      run(0, rows[k].a, rows[k].w, r, q);
      check(r, rows[k].r);
      if (!rows[k].w && rows[k].r == 2'h0) check(q, rows[k].q);
      check({cs_acc, ps_acc}, {rows[k].cs, rows[k].ps});
      check(ext_addr_q, rows[k].a);
      check(paddr_q, rows[k].a);
      check({ext_write_q, pwrite_q}, {2{rows[k].w}});
      check(ext_wdata_q, WD);
      check(pwdata_q, WD);
      $display("row %0d done", k);
    end
    // Local port write, aliased read, then the boot view of the same word.
    lsram_en = 1'b1;
    lsram_we = 1'b1;
    lsram_addr = 32'h8000_0020;
    lsram_wdata = WD;
    @(negedge clk_sys);
    lsram_we = 1'b0;
    lsram_addr = 32'h8000_4020;
    @(negedge clk_sys);
    lsram_en = 1'b0;
    check(lsram_rdata, WD);
    map_sel = 2'h2;
    run(0, 32'h0000_0020, 1'b0, r, q);
    check(q, WD);
    // The fixed local segment aliases too; a non-processor master is refused.
    run(0, 32'h8000_4020, 1'b0, r, q);
    check(q, WD);
    run(1, 32'h8000_0020, 1'b0, r, q);
    check(r, 2'h1);
    $display("local sram done");
    // Three masters contend; the processor asks one cycle late so priority decides.
    fork
      begin run(2, 32'h6000_0010, 1'b0, r, q); order.push_back(2); check(q, WD); end
      begin run(1, 32'h6000_0010, 1'b0, r, q); order.push_back(1); end
      begin @(negedge clk_sys); run(0, 32'h6000_0010, 1'b0, r, q); order.push_back(0); end
    join
    check({8'(order[0]), 8'(order[1]), 8'(order[2])}, 32'h0002_0100);
    repeat (4) @(negedge clk_sys);
    check(grant_reg, 3'h1);
    $display("arbitration done");
    // Reset in the middle of a slow external read, then a clean transfer.
    mr[1] = '{1'b1, 2'h2, 1'b0, 32'h4000_0000, WD};
    repeat (3) @(negedge clk_sys);
    rst(2);
    run(0, 32'h6000_0010, 1'b0, r, q);
    check(r, 2'h0);
    $display("mid-run reset done");
    conclude();
  end
endmodule
bind sbda_fabric sbda_fabric_checker i_chk (.clk_sys, .rstn, .disp_req, .xfer_req, .cpu_req, .grant_reg,
  .resp_reg, .lsram_en, .lsram_we, .lsram_addr, .lsram_wdata, .lsram_rdata, .ext_cs_reg, .psel_reg, .penable_reg);
`default_nettype wire
